// File: common/rcr_pkg.sv
package rcr_pkg;

  // Register byte addresses
  localparam int          ADDR_W       = 5;
  localparam logic [4:0]  OFF_MINUTE   = 5'h00;
  localparam logic [4:0]  OFF_MONTH    = 5'h04;
  localparam logic [4:0]  OFF_YEAR     = 5'h08;
  localparam logic [4:0]  OFF_FLAGS    = 5'h0C;
  localparam logic [4:0]  OFF_ENABLE   = 5'h10;
  localparam logic [4:0]  OFF_STATUS   = 5'h14;

  // Implemented bits of each register; the rest read as zero
  localparam logic [15:0] MINUTE_MASK  = 16'h007F;
  localparam logic [15:0] MONTH_MASK   = 16'h1F3F;
  localparam logic [15:0] YEAR_MASK    = 16'h07FF;
  localparam logic [15:0] EVT_MASK     = 16'hF1FF;

  // Reset values
  localparam logic [15:0] MINUTE_RST   = 16'h0000;
  localparam logic [15:0] MONTH_RST    = 16'h0101;
  localparam logic [15:0] YEAR_RST     = 16'h0000;
  localparam logic [15:0] FLAG_RST     = 16'h0000;
  localparam logic [5:0]  DAY_LIM_RST  = 6'h31;

  // Field positions
  localparam int          MIN_ONES_LSB = 0;
  localparam int          MIN_TENS_LSB = 4;
  localparam int          DAY_LSB      = 0;
  localparam int          MON_LSB      = 8;
  localparam int          YEAR_LSB     = 0;
  localparam int          WEEK_LSB     = 8;
  localparam int          BUSY_BIT     = 0;

  // Event flag positions
  localparam int          BIT_REG_DONE = 15;
  localparam int          BIT_SW_1HZ   = 14;
  localparam int          BIT_SW_10HZ  = 13;
  localparam int          BIT_SW_100HZ = 12;
  localparam int          BIT_ALARM    = 8;
  localparam int          BIT_DAY      = 7;
  localparam int          BIT_HOUR     = 6;
  localparam int          BIT_MINUTE   = 5;
  localparam int          BIT_SECOND   = 4;
  localparam int          BIT_HALF     = 3;
  localparam int          BIT_QUARTER  = 2;
  localparam int          BIT_EIGHTH   = 1;
  localparam int          BIT_32ND     = 0;

  // Range limits in BCD
  localparam logic [7:0]  MINUTE_MAX   = 8'h59;
  localparam logic [7:0]  MONTH_MAX    = 8'h12;
  localparam logic [7:0]  YEAR_MAX     = 8'h99;
  localparam logic [2:0]  WEEK_MAX     = 3'h6;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] rcr_merge(input logic [15:0] old_v,
    input logic [15:0] new_v, input logic [1:0] strb);
    rcr_merge = {strb[1] ? new_v[15:8] : old_v[15:8],
                 strb[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  // Two-digit BCD check against an upper limit
  function automatic logic rcr_bcd_ok(input logic [7:0] v,
    input logic [7:0] max);
    rcr_bcd_ok = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v <= max);
  endfunction

  // Last day of a month, BCD, leap years from the BCD year
  function automatic logic [5:0] rcr_days(input logic [4:0] mon,
    input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                    yr[3:0] == 4'h8);
    case (mon)
      5'h02:   rcr_days = leap ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: rcr_days = 6'h30;
      default: rcr_days = 6'h31;
    endcase
  endfunction

endpackage

// File: rtl/rcr_axil.sv
`timescale 1ns/10ps
// AXI4-Lite slave turning bus traffic into register strobes
module rcr_axil
  import rcr_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [15:0]            wr_data,
  output logic [1:0]             wr_strb,
  input  wire logic              wr_ok,
  output logic                   rd_en,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [15:0]       rd_data,
  input  wire logic              rd_ok
);

  typedef struct packed {
    logic              aw_full;
    logic [ADDR_W-1:0] awaddr;
    logic              w_full;
    logic [15:0]       wdata;
    logic [1:0]        wstrb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [15:0]       rdata;
    logic [1:0]        rresp;
  } rcr_bus_t;

  rcr_bus_t bus_q;
  rcr_bus_t bus_d;

  // Register strobes toward the register file
  assign wr_en   = bus_q.aw_full && bus_q.w_full && !bus_q.bvalid;
  assign wr_addr = bus_q.awaddr;
  assign wr_data = bus_q.wdata;
  assign wr_strb = bus_q.wstrb;
  assign rd_en   = s_axi_arvalid && bus_q.arready;
  assign rd_addr = s_axi_araddr;

  // Channel handshakes; address and data may arrive in either order
  always_comb
  begin
    bus_d = bus_q;
    if (s_axi_awvalid && bus_q.awready)
    begin
      bus_d.aw_full = 1'b1;
      bus_d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && bus_q.wready)
    begin
      bus_d.w_full = 1'b1;
      bus_d.wdata  = s_axi_wdata[15:0];
      bus_d.wstrb  = s_axi_wstrb[1:0];
    end
    if (wr_en)
    begin
      bus_d.aw_full = 1'b0;
      bus_d.w_full  = 1'b0;
      bus_d.bvalid  = 1'b1;
      bus_d.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (bus_q.bvalid && s_axi_bready)
      bus_d.bvalid = 1'b0;
    if (rd_en)
    begin
      bus_d.rvalid = 1'b1;
      bus_d.rdata  = rd_data;
      bus_d.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bus_q.rvalid && s_axi_rready)
      bus_d.rvalid = 1'b0;
    bus_d.awready = !bus_d.aw_full && !bus_d.bvalid;
    bus_d.wready  = !bus_d.w_full && !bus_d.bvalid;
    bus_d.arready = !bus_d.rvalid;
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bus_q <= '0;
    else
      bus_q <= bus_d;
  end

  assign s_axi_awready = bus_q.awready;
  assign s_axi_wready  = bus_q.wready;
  assign s_axi_bvalid  = bus_q.bvalid;
  assign s_axi_bresp   = bus_q.bresp;
  assign s_axi_arready = bus_q.arready;
  assign s_axi_rvalid  = bus_q.rvalid;
  assign s_axi_rdata   = {16'h0000, bus_q.rdata};
  assign s_axi_rresp   = bus_q.rresp;

endmodule // rcr_axil

// File: rtl/rcr_regs.sv
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
// What this block does
// - Minute held as BCD tens/ones, 0 to 59
// - Month BCD at bits 12..8, 1 to 12
// - Day BCD from 1, monthly and leap limits
// - Weekday held at bits 10..8, 0 to 6, zero is Sunday
// - Year BCD at bits 7..0, 0 to 99
// - Flags sticky until one written back
// - Regulation and stopwatch flags in bits 15..12
// - Alarm and time tick flags in bits 8..0
// - Enable bits align with flags, readable back
module rcr_regs
  import rcr_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              clock_busy_flag,
  input  wire logic [15:0]       event_pulses,
  output logic [15:0]            minute_word,
  output logic [15:0]            month_day_word,
  output logic [15:0]            year_week_word,
  output logic [5:0]             day_limit,
  output logic                   rtc_irq
);

  typedef struct packed {
    logic [15:0] minute;
    logic [15:0] month_day;
    logic [15:0] year_week;
    logic [15:0] flags;
    logic [15:0] enables;
    logic [5:0]  day_limit;
    logic        irq;
  } rcr_state_t;

  rcr_state_t        st_q;
  rcr_state_t        st_d;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [15:0]       wr_data;
  logic [1:0]        wr_strb;
  logic              wr_ok;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [15:0]       rd_data;
  logic              rd_ok;
  logic [15:0]       wr_merged;
  logic [15:0]       lane_mask;
  logic [15:0]       flag_clear;
  logic              cnt_wr_ok;

  // Bus slave front end
  rcr_axil u_axil (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_ok         (wr_ok),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok)
  );

  // Address decode shared by reads and writes
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == OFF_MINUTE) || (a == OFF_MONTH) || (a == OFF_YEAR) ||
             (a == OFF_FLAGS) || (a == OFF_ENABLE) || (a == OFF_STATUS);
  endfunction

  // Write helpers; counters refuse writes while the chain is busy
  assign wr_ok      = mapped(wr_addr);
  assign lane_mask  = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign flag_clear = (wr_en && wr_addr == OFF_FLAGS) ?
                      (wr_data & lane_mask & EVT_MASK) : 16'h0000;
  assign cnt_wr_ok  = wr_en && !clock_busy_flag;

  // Next state of every register
  always_comb
  begin
    logic [15:0] nv;
    logic [7:0]  mon;
    logic [7:0]  day;
    logic [5:0]  lim;
    nv  = 16'h0000;
    mon = 8'h00;
    day = 8'h00;
    lim = 6'h00;
    st_d = st_q;
    wr_merged = 16'h0000;
    case (wr_addr)
      OFF_MINUTE: wr_merged = rcr_merge(st_q.minute, wr_data, wr_strb);
      OFF_MONTH:  wr_merged = rcr_merge(st_q.month_day, wr_data, wr_strb);
      OFF_YEAR:   wr_merged = rcr_merge(st_q.year_week, wr_data, wr_strb);
      OFF_ENABLE: wr_merged = rcr_merge(st_q.enables, wr_data, wr_strb);
      default:    wr_merged = 16'h0000;
    endcase
    if (cnt_wr_ok && wr_addr == OFF_MINUTE)
    begin
      nv = wr_merged & MINUTE_MASK;
      if (rcr_bcd_ok(nv[7:0], MINUTE_MAX))
        st_d.minute = nv;
    end
    if (cnt_wr_ok && wr_addr == OFF_MONTH)
    begin
      nv  = wr_merged & MONTH_MASK;
      mon = {3'h0, nv[MON_LSB +: 5]};
      day = {2'h0, nv[DAY_LSB +: 6]};
      lim = rcr_days(mon[4:0], st_q.year_week[YEAR_LSB +: 8]);
      // Zero month and out-of-range days are refused
      if (mon != 8'h00 && rcr_bcd_ok(mon, MONTH_MAX) &&
          day != 8'h00 && rcr_bcd_ok(day, {2'h0, lim}))
        st_d.month_day = nv;
    end
    if (cnt_wr_ok && wr_addr == OFF_YEAR)
    begin
      nv  = wr_merged & YEAR_MASK;
      lim = rcr_days(st_q.month_day[MON_LSB +: 5], nv[YEAR_LSB +: 8]);
      // A new year must not strand a leap day in a common year
      if (rcr_bcd_ok(nv[YEAR_LSB +: 8], YEAR_MAX) &&
          nv[WEEK_LSB +: 3] <= WEEK_MAX &&
          st_q.month_day[DAY_LSB +: 6] <= lim)
        st_d.year_week = nv;
    end
    if (wr_en && wr_addr == OFF_ENABLE)
      st_d.enables = wr_merged & EVT_MASK;
    // Events win over a clear in the same cycle
    st_d.flags = ((st_q.flags & ~flag_clear) | event_pulses)
                 & EVT_MASK;
    st_d.day_limit = rcr_days(st_d.month_day[MON_LSB +: 5],
                              st_d.year_week[YEAR_LSB +: 8]);
    st_d.irq = |(st_d.flags & st_d.enables);
  end

  // State register with documented initial values
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q.minute    <= MINUTE_RST;
      st_q.month_day <= MONTH_RST;
      st_q.year_week <= YEAR_RST;
      st_q.flags     <= FLAG_RST;
      st_q.enables   <= FLAG_RST;
      st_q.day_limit <= DAY_LIM_RST;
      st_q.irq       <= 1'b0;
    end
    else
      st_q <= st_d;
  end

  // Read multiplexer; unmapped reads answer zero with an error
  // Status shows the busy level live so software can poll it
  always_comb
  begin
    rd_ok = mapped(rd_addr);
    case (rd_addr)
      OFF_MINUTE: rd_data = st_q.minute;
      OFF_MONTH:  rd_data = st_q.month_day;
      OFF_YEAR:   rd_data = st_q.year_week;
      OFF_FLAGS:  rd_data = st_q.flags;
      OFF_ENABLE: rd_data = st_q.enables;
      OFF_STATUS: rd_data = 16'(clock_busy_flag) << BUSY_BIT;
      default:    rd_data = 16'h0000;
    endcase
  end

  // Outputs straight from the state register
  assign minute_word    = st_q.minute;
  assign month_day_word = st_q.month_day;
  assign year_week_word = st_q.year_week;
  assign day_limit      = st_q.day_limit;
  assign rtc_irq        = st_q.irq;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Assertions on the held fields and the flag logic
  chk_minute_range: assert property (
    rcr_bcd_ok(st_q.minute[7:0], MINUTE_MAX))
    else $error("minute field out of range");

  chk_month_range: assert property (
    st_q.month_day[MON_LSB +: 5] != 5'h00 &&
    rcr_bcd_ok({3'h0, st_q.month_day[MON_LSB +: 5]}, MONTH_MAX))
    else $error("month field out of range");

  chk_day_limit: assert property (
    st_q.month_day[DAY_LSB +: 6] != 6'h00 &&
    st_q.month_day[DAY_LSB +: 6] <= st_q.day_limit)
    else $error("day above monthly limit");

  chk_week_range: assert property (
    st_q.year_week[WEEK_LSB +: 3] <= WEEK_MAX)
    else $error("weekday above six");

  chk_year_range: assert property (
    rcr_bcd_ok(st_q.year_week[YEAR_LSB +: 8], YEAR_MAX))
    else $error("year field out of range");

  chk_busy_guard: assert property (
    wr_en && clock_busy_flag |=> $stable(st_q.minute) &&
    $stable(st_q.month_day) && $stable(st_q.year_week))
    else $error("counter changed by write while busy");

  chk_flag_sticky: assert property (
    1'b1 |=> ($past(st_q.flags) & ~$past(flag_clear) & ~st_q.flags)
             == 16'h0000)
    else $error("flag dropped without a clear");

  chk_event_sets: assert property (
    |(event_pulses & EVT_MASK) |=>
    ($past(event_pulses) & EVT_MASK & ~st_q.flags) == 16'h0000)
    else $error("event did not set its flag");

  chk_enable_back: assert property (
    wr_en && wr_addr == OFF_ENABLE && wr_strb == 2'h3 |=>
    st_q.enables == ($past(wr_data) & EVT_MASK))
    else $error("enable readback mismatch");

  chk_irq_level: assert property (
    rtc_irq == |(st_q.flags & st_q.enables))
    else $error("interrupt disagrees with flags");

  chk_reserved_zero: assert property (
    (st_q.flags & ~EVT_MASK) == 16'h0000 &&
    (st_q.enables & ~EVT_MASK) == 16'h0000 &&
    (st_q.month_day & ~MONTH_MASK) == 16'h0000)
    else $error("reserved bit set");

  // A written one clears its flag unless an event sets it again
  chk_flag_clear: assert property (
    |flag_clear |=>
    ($past(flag_clear) & ~$past(event_pulses) & st_q.flags) == 16'h0000)
    else $error("written one did not clear its flag");

  chk_reserved_count: assert property (
    (st_q.minute & ~MINUTE_MASK) == 16'h0000 &&
    (st_q.year_week & ~YEAR_MASK) == 16'h0000)
    else $error("reserved counter bit set");

  // Month length follows the month; February is 28 or 29
  chk_short_month: assert property (
    st_q.month_day[MON_LSB +: 5] inside {5'h04, 5'h06, 5'h09, 5'h11} |->
    day_limit == 6'h30)
    else $error("thirty-day month limit wrong");

  chk_feb_limit: assert property (
    st_q.month_day[MON_LSB +: 5] == 5'h02 |->
    day_limit == 6'h28 || day_limit == 6'h29)
    else $error("february limit wrong");

  // Main scenarios
  cov_irq_raise: cover property (!rtc_irq ##1 rtc_irq);
  cov_set_clear: cover property (
    |(flag_clear & event_pulses) ##1 |st_q.flags);
  cov_busy_write: cover property (wr_en && clock_busy_flag);
  cov_leap_day: cover property (
    st_q.month_day[DAY_LSB +: 6] == 6'h29 && day_limit == 6'h29);
  cov_year_refused: cover property (
    cnt_wr_ok && wr_addr == OFF_YEAR ##1 $stable(st_q.year_week));

endmodule // rcr_regs

// File: testbench/tb.sv
`timescale 1ns/10ps
// Self-checking bench for the calendar and event registers
module tb
  import rcr_pkg::*;
;
  logic              aclk            = 1'b0;
  logic              aresetn         = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr    = '0;
  logic              s_axi_awvalid   = 1'b0;
  logic              s_axi_awready;
  logic [31:0]       s_axi_wdata     = '0;
  logic [3:0]        s_axi_wstrb     = '0;
  logic              s_axi_wvalid    = 1'b0;
  logic              s_axi_wready;
  logic [1:0]        s_axi_bresp;
  logic              s_axi_bvalid;
  logic              s_axi_bready    = 1'b0;
  logic [ADDR_W-1:0] s_axi_araddr    = '0;
  logic              s_axi_arvalid   = 1'b0;
  logic              s_axi_arready;
  logic [31:0]       s_axi_rdata;
  logic [1:0]        s_axi_rresp;
  logic              s_axi_rvalid;
  logic              s_axi_rready    = 1'b0;
  logic              clock_busy_flag = 1'b0;
  logic [15:0]       event_pulses    = '0;
  logic [15:0]       minute_word;
  logic [15:0]       month_day_word;
  logic [15:0]       year_week_word;
  logic [5:0]        day_limit;
  logic              rtc_irq;
  logic [33:0]       exp_q[$];
  logic [33:0]       note;
  logic [31:0]       rnd;
  logic [15:0]       en_v;
  logic [15:0]       ev_v;
  logic [15:0]       one_v;
  logic [15:0]       evt_m           = 16'hF1FF;
  int                miscompares     = 0;
  int                checks_done     = 0;
  int                cyc             = 0;

  rcr_regs rcr_regs_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .clock_busy_flag(clock_busy_flag),
    .event_pulses(event_pulses), .minute_word(minute_word),
    .month_day_word(month_day_word), .year_week_word(year_week_word),
    .day_limit(day_limit), .rtc_irq(rtc_irq)
  );

  // Free-running 125 MHz clock
  always #4 aclk = ~aclk;

  // Compare one value and count it
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  // Print the counts and the verdict, then stop
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Write one word; address and data offered together
  task automatic wr(input logic [4:0] a, input logic [15:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_wstrb   <= 4'h3;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask

  // Read one word; the expectation goes to the queue
  task automatic rd(input logic [4:0] a, input logic [15:0] e,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    exp_q.push_back({er, 16'h0000, e});
    forever
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
  endtask

  // Write then read back the same register
  task automatic wr_rd(input logic [4:0] a, input logic [15:0] d,
                       input logic [15:0] e);
    wr(a, d, RESP_OKAY);
    rd(a, e, RESP_OKAY);
  endtask

  // One-cycle event pulse, then let the flag settle
  task automatic pulse(input logic [15:0] v);
    @(posedge aclk);
    event_pulses <= v;
    @(posedge aclk);
    event_pulses <= 16'h0000;
    @(posedge aclk);
  endtask

  // Read monitor: oldest note against each read answer
  always @(posedge aclk)
  begin
    if (aresetn && s_axi_rvalid && s_axi_rready)
    begin
      if (exp_q.size() == 0)
        chk("read note", 32'h0, 32'h1);
      else
      begin
        note = exp_q.pop_front();
        chk("rdata", note[31:0], s_axi_rdata);
        chk("rresp", {30'h0, note[33:32]}, {30'h0, s_axi_rresp});
      end
    end
  end

  // Hang guard
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      finish_test();
    end
  end

  // Main sequence
  initial
  begin
    rnd = $urandom(32'hEC46);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("day_limit", 32'h31, {26'h0, day_limit});
    chk("rtc_irq", 32'h0, {31'h0, rtc_irq});
    rd(OFF_MINUTE, 16'h0000, RESP_OKAY);
    rd(OFF_MONTH, 16'h0101, RESP_OKAY);
    rd(OFF_YEAR, 16'h0000, RESP_OKAY);
    rd(OFF_FLAGS, 16'h0000, RESP_OKAY);
    rd(OFF_ENABLE, 16'h0000, RESP_OKAY);
    // Minute range and reserved bits
    wr_rd(OFF_MINUTE, 16'h0059, 16'h0059);
    wr_rd(OFF_MINUTE, 16'h0060, 16'h0059);
    wr_rd(OFF_MINUTE, 16'h005A, 16'h0059);
    wr_rd(OFF_MINUTE, 16'hFFA3, 16'h0023);
    chk("minute_word", 32'h23, {16'h0, minute_word});
    // Month, day and leap-year limits
    wr_rd(OFF_YEAR, 16'h0001, 16'h0001);
    wr_rd(OFF_MONTH, 16'h0229, 16'h0101);
    wr_rd(OFF_MONTH, 16'h0228, 16'h0228);
    chk("day_limit", 32'h28, {26'h0, day_limit});
    wr_rd(OFF_MONTH, 16'h0101, 16'h0101);
    wr_rd(OFF_YEAR, 16'h0024, 16'h0024);
    wr_rd(OFF_MONTH, 16'h0229, 16'h0229);
    chk("day_limit", 32'h29, {26'h0, day_limit});
    wr_rd(OFF_YEAR, 16'h0025, 16'h0024);
    wr_rd(OFF_MONTH, 16'h0431, 16'h0229);
    wr_rd(OFF_MONTH, 16'h1130, 16'h1130);
    chk("day_limit", 32'h30, {26'h0, day_limit});
    wr_rd(OFF_MONTH, 16'h0015, 16'h1130);
    wr_rd(OFF_MONTH, 16'h1301, 16'h1130);
    wr_rd(OFF_MONTH, 16'hF2F1, 16'h1231);
    chk("month_day_word", 32'h1231, {16'h0, month_day_word});
    // Year and weekday
    wr_rd(OFF_YEAR, 16'h009A, 16'h0024);
    wr_rd(OFF_YEAR, 16'h0799, 16'h0024);
    for (int w = 0; w < 7; w++)
    begin
      one_v = {5'h1F, 3'(w), 8'h99};
      wr_rd(OFF_YEAR, one_v, one_v & YEAR_MASK);
    end
    chk("year_week_word", 32'h0699, {16'h0, year_week_word});
    // Counter writes refused while busy
    @(posedge aclk);
    clock_busy_flag <= 1'b1;
    rd(OFF_STATUS, 16'h0001, RESP_OKAY);
    wr_rd(OFF_MINUTE, 16'h0011, 16'h0023);
    wr_rd(OFF_MONTH, 16'h0101, 16'h1231);
    wr_rd(OFF_YEAR, 16'h0000, 16'h0699);
    @(posedge aclk);
    clock_busy_flag <= 1'b0;
    rd(OFF_STATUS, 16'h0000, RESP_OKAY);
    // Unmapped addresses
    wr(5'h18, 16'h1234, RESP_SLVERR);
    rd(5'h1C, 16'h0000, RESP_SLVERR);
    // Each flag position, masked then enabled, then cleared
    for (int i = 0; i < 16; i++)
    begin
      one_v = 16'h0001 << i;
      wr(OFF_ENABLE, 16'h0000, RESP_OKAY);
      pulse(one_v);
      chk("rtc_irq masked", 32'h0, {31'h0, rtc_irq});
      rd(OFF_FLAGS, one_v & evt_m, RESP_OKAY);
      wr(OFF_ENABLE, one_v, RESP_OKAY);
      chk("rtc_irq", {31'h0, evt_m[i]}, {31'h0, rtc_irq});
      wr_rd(OFF_FLAGS, one_v, 16'h0000);
      chk("rtc_irq cleared", 32'h0, {31'h0, rtc_irq});
    end
    // An event held through its clear keeps the flag set
    @(posedge aclk);
    event_pulses <= 16'h0010;
    wr_rd(OFF_FLAGS, 16'h0010, 16'h0010);
    @(posedge aclk);
    event_pulses <= 16'h0000;
    rd(OFF_FLAGS, 16'h0010, RESP_OKAY);
    wr_rd(OFF_FLAGS, 16'h0010, 16'h0000);
    // Random enables and events
    repeat (6)
    begin
      rnd = $urandom();
      en_v = rnd[15:0];
      ev_v = rnd[31:16];
      wr_rd(OFF_ENABLE, en_v, en_v & evt_m);
      pulse(ev_v);
      one_v = en_v & ev_v & evt_m;
      chk("rtc_irq", {31'h0, |one_v}, {31'h0, rtc_irq});
      wr_rd(OFF_FLAGS, 16'h0000, ev_v & evt_m);
      wr_rd(OFF_FLAGS, 16'hFFFF, 16'h0000);
      chk("rtc_irq", 32'h0, {31'h0, rtc_irq});
    end
    // Reset in mid-run with a flag pending
    pulse(16'h0100);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("rtc_irq", 32'h0, {31'h0, rtc_irq});
    chk("minute_word", 32'h0, {16'h0, minute_word});
    rd(OFF_FLAGS, 16'h0000, RESP_OKAY);
    rd(OFF_MONTH, 16'h0101, RESP_OKAY);
    rd(OFF_YEAR, 16'h0000, RESP_OKAY);
    repeat (4) @(posedge aclk);
    finish_test();
  end

endmodule // tb
